// file: include/bss_pkg.sv
// Constants shared by the burst static RAM control logic.
// Assumes a single 200 MHz clock domain and nothing imported.
package bss_pkg;
    localparam int ADDR_W      = 15;
    localparam int DATA_W      = 18;
    localparam int HALF_W      = 9;
    localparam int BURST_W     = 2;
    localparam int FIFO_DEPTH  = 16;
    localparam int SYNC_STAGES = 3;
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    typedef enum logic [1:0] {
        BSS_DESELECT,
        BSS_READ,
        BSS_WRITE
    } bss_mode_t;
endpackage

// file: hw/bss_fifo.sv
// Synchronous FIFO of flip-flops for the read data path.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/10ps
`default_nettype none
module bss_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rstN,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wrPtr;
    logic [AW-1:0]    next_rdPtr;
    logic [AW:0]      next_count;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_comb begin
        doWr       = inValid && inReady;
        doRd       = outValid && outReady;
        next_wrPtr = doWr ? ((wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1) : wrPtr;
        next_rdPtr = doRd ? ((rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1) : rdPtr;
        next_count = count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage holds no reset value; the count says what is valid.
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule
`default_nettype wire

// file: hw/bss_control.sv
// Top of the burst static RAM: pin sampling, address and burst logic, array.
// Assumes pins come from another domain; output enable is a raw pin.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Select holds until deselect by controller strobe
// - Processor strobe ignored while chip deselected
// - Blocked strobe still allows advance and writes
// - Address register loads only on selected strobe
// - Selected processor strobe always begins read
// - Controller strobe begins read or write directly
// - Both strobes high, step low: next address
// - Both strobes high, step high: hold address
// - Only two low address bits cycle
// - Powered-down device stays down when continuing
// - Selected strobe start powers the device up
// - All but output enable sampled on clock
// - Read with enable low drives stored word
// - Write or deselect keeps drivers off
// - Two-bit counter clears on start, XORed into low address bits
// - Separate upper and lower byte writes
// - Registered write completes from one edge
module bss_control #(
    parameter int ADDR_W = bss_pkg::ADDR_W,
    parameter int DATA_W = bss_pkg::DATA_W
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              chip_sel_n,
    input  wire logic              proc_addr_strobe_n,
    input  wire logic              ctrl_addr_strobe_n,
    input  wire logic              burst_step_n,
    input  wire logic              upper_byte_wr_n,
    input  wire logic              lower_byte_wr_n,
    input  wire logic              out_enable_n,
    input  wire logic [ADDR_W-1:0] word_address,
    input  wire logic [DATA_W-1:0] data_pins_in,
    output logic      [DATA_W-1:0] data_pins_out,
    output logic                   data_pins_oe,
    output logic                   powered_up,
    output logic                   read_valid,
    input  wire logic              read_ready,
    output logic      [DATA_W-1:0] read_data
);
    localparam int BW = bss_pkg::BURST_W;
    localparam int HW = bss_pkg::HALF_W;
    localparam int NIN = 7 + ADDR_W + DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and input sampling.
    logic [1:0] rstSync;
    logic       rstN;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    logic [NIN-1:0] pinRaw;
    logic [NIN-1:0] pinS1;
    logic [NIN-1:0] pinS2;
    logic [NIN-1:0] pinS3;
    logic [NIN-1:0] pinQ;
    logic [NIN-1:0] next_pinQ;
    assign pinRaw = {chip_sel_n, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n,
                     upper_byte_wr_n, lower_byte_wr_n, 1'b0, word_address, data_pins_in};

    // A pin counts once the second and third stages agree; else the old value stays.
    always_comb begin
        for (int i = 0; i < NIN; i++) begin
            next_pinQ[i] = (pinS2[i] == pinS3[i]) ? pinS3[i] : pinQ[i];
        end
    end

    // Strobes idle high, so reset fills the chain with ones.
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinS1 <= '1;
            pinS2 <= '1;
            pinS3 <= '1;
            pinQ  <= '1;
        end else begin
            pinS1 <= pinRaw;
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            pinQ  <= next_pinQ;
        end
    end

    logic              csN;
    logic              apN;
    logic              acN;
    logic              advN;
    logic              uwN;
    logic              lwN;
    logic [ADDR_W-1:0] extAddr;
    logic [DATA_W-1:0] dinQ;
    assign csN     = pinQ[NIN-1];
    assign apN     = pinQ[NIN-2];
    assign acN     = pinQ[NIN-3];
    assign advN    = pinQ[NIN-4];
    assign uwN     = pinQ[NIN-5];
    assign lwN     = pinQ[NIN-6];
    assign extAddr = pinQ[ADDR_W+DATA_W-1:DATA_W];
    assign dinQ    = pinQ[DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Address, burst counter and select state.
    function automatic logic [BW-1:0] burstLow(input logic [BW-1:0] b,
                                                input logic [BW-1:0] c);
        burstLow = b ^ c;
    endfunction

    logic [ADDR_W-1:0]  baseAddr;
    logic [BW-1:0]      cnt;
    logic               up;
    bss_pkg::bss_mode_t mode;
    logic [ADDR_W-1:0]  next_baseAddr;
    logic [BW-1:0]      next_cnt;
    logic               next_up;
    bss_pkg::bss_mode_t next_mode;
    logic               startP;
    logic               startC;
    logic               anyWr;

    always_comb begin
        anyWr         = !(uwN && lwN);
        startP        = !csN && !apN;
        startC        = !csN && apN && !acN;
        next_baseAddr = baseAddr;
        next_cnt      = cnt;
        next_up       = up;
        next_mode     = mode;
        if (csN && !acN) begin
            next_up   = 1'b0;
            next_mode = bss_pkg::BSS_DESELECT;
        end else if (startP) begin
            next_baseAddr = extAddr;
            next_cnt      = bss_pkg::BURST_ZERO;
            next_up       = 1'b1;
            next_mode     = bss_pkg::BSS_READ;
        end else if (startC) begin
            next_baseAddr = extAddr;
            next_cnt      = bss_pkg::BURST_ZERO;
            next_up       = 1'b1;
            next_mode     = anyWr ? bss_pkg::BSS_WRITE : bss_pkg::BSS_READ;
        end else begin
            // Both strobes high, or a processor strobe blocked by chip select;
            // the burst carries on either way. Wrap comes from the counter's width.
            if (!advN) begin
                next_cnt = cnt + bss_pkg::BURST_ONE;
            end
            // A powered-down device stays in deselect here.
            if (up) begin
                next_mode = anyWr ? bss_pkg::BSS_WRITE : bss_pkg::BSS_READ;
            end else begin
                next_mode = bss_pkg::BSS_DESELECT;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            baseAddr <= '0;
            cnt      <= bss_pkg::BURST_ZERO;
            up       <= 1'b0;
            mode     <= bss_pkg::BSS_DESELECT;
        end else begin
            baseAddr <= next_baseAddr;
            cnt      <= next_cnt;
            up       <= next_up;
            mode     <= next_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array with self-timed byte-half writes from registered controls.
    logic [ADDR_W-1:0] curAddr;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic              wrUpper;
    logic              wrLower;
    logic [DATA_W-1:0] rdWord;
    logic              rdPending;
    logic              next_rdPending;
    assign curAddr = {baseAddr[ADDR_W-1:BW], burstLow(baseAddr[BW-1:0], cnt)};
    // The write uses the enables and data of the edge that set write mode.
    logic uwQ;
    logic lwQ;
    logic [DATA_W-1:0] dinR;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            uwQ  <= 1'b1;
            lwQ  <= 1'b1;
            dinR <= '0;
        end else begin
            uwQ  <= uwN;
            lwQ  <= lwN;
            dinR <= dinQ;
        end
    end
    assign wrUpper = (mode == bss_pkg::BSS_WRITE) && !uwQ;
    assign wrLower = (mode == bss_pkg::BSS_WRITE) && !lwQ;
    always_ff @(posedge clk) begin
        if (wrUpper) begin
            mem[curAddr][DATA_W-1:HW] <= dinR[DATA_W-1:HW];
        end
        if (wrLower) begin
            mem[curAddr][HW-1:0] <= dinR[HW-1:0];
        end
    end

    always_comb begin
        next_rdPending = (mode == bss_pkg::BSS_READ);
    end
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdWord    <= '0;
            rdPending <= 1'b0;
        end else begin
            rdWord    <= mem[curAddr];
            rdPending <= next_rdPending;
        end
    end

    // Pins: output enable acts combinationally, never through the samplers.
    assign data_pins_out = rdWord;
    assign data_pins_oe  = rdPending && (mode == bss_pkg::BSS_READ) && !out_enable_n;
    assign powered_up    = up;

    ////////////////////////////////////////////////////////////////////////
    // Read words are also queued for local consumers; a full queue drops none
    // of the pin behaviour but skips words, which is a documented limitation.
    logic fifoInReady;
    bss_fifo #(.WIDTH(DATA_W), .DEPTH(bss_pkg::FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .rstN     (rstN),
        .inValid  (rdPending && fifoInReady),
        .inReady  (fifoInReady),
        .inData   (rdWord),
        .outValid (read_valid),
        .outReady (read_ready),
        .outData  (read_data)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence deselSeq;
        csN && !acN;
    endsequence
    sequence procStartSeq;
        !csN && !apN;
    endsequence

    deselect_power_a: assert property (@(posedge clk) disable iff (!rstN)
        deselSeq |=> !up && mode == bss_pkg::BSS_DESELECT)
        else $error("deselect did not power down");
    blocked_strobe_a: assert property (@(posedge clk) disable iff (!rstN)
        csN && !apN && acN |=> $stable(baseAddr) && up == $past(up))
        else $error("blocked strobe changed state");
    blocked_step_a: assert property (@(posedge clk) disable iff (!rstN)
        csN && !apN && acN && !advN |=> cnt == $past(cnt) + 2'h1)
        else $error("blocked strobe stopped the burst");
    addr_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        !(!csN && !(apN && acN)) |=> $stable(baseAddr))
        else $error("address changed without selected strobe");
    proc_read_a: assert property (@(posedge clk) disable iff (!rstN)
        procStartSeq |=> mode == bss_pkg::BSS_READ && baseAddr == $past(extAddr) && cnt == 2'h0)
        else $error("processor start not a read");
    ctrl_start_a: assert property (@(posedge clk) disable iff (!rstN)
        !csN && apN && !acN && !(uwN && lwN) |=> mode == bss_pkg::BSS_WRITE)
        else $error("controller write start missed");
    burst_step_a: assert property (@(posedge clk) disable iff (!rstN)
        apN && acN && !advN |=> cnt == $past(cnt) + 2'h1)
        else $error("burst did not step");
    burst_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        apN && acN && advN |=> $stable(cnt))
        else $error("burst did not hold");
    stay_down_a: assert property (@(posedge clk) disable iff (!rstN)
        !up && apN && acN |=> !up && mode == bss_pkg::BSS_DESELECT)
        else $error("powered-down device woke");
    drive_off_a: assert property (@(posedge clk) disable iff (!rstN)
        mode != bss_pkg::BSS_READ |-> !data_pins_oe)
        else $error("drivers on outside read");
endmodule
`default_nettype wire

// file: bench/bss_host.sv
// Model of the processor and cache controller that share the pin bus.
// Assumes the bench merges the write data with the block's own drivers.
`timescale 1ns/10ps
`default_nettype none
module bss_host (
    input  wire logic        clk,
    output logic             chipSelN,
    output logic             procStrobeN,
    output logic             ctrlStrobeN,
    output logic             stepN,
    output logic             upperWrN,
    output logic             lowerWrN,
    output logic             outEnN,
    output logic      [14:0] address,
    output logic      [17:0] wrData
);
    logic readOeN;
    initial begin
        {chipSelN, procStrobeN, ctrlStrobeN, stepN, upperWrN, lowerWrN} = 6'h37;
        outEnN = 1'b1;
        readOeN = 1'b0;
        address = 15'h0000;
        wrData = 18'h00000;
    end
    // Chip select is driven as asked, so a processor strobe can be held off.
    task automatic cycle(input logic [5:0] ctl, input logic [14:0] a, input logic [17:0] d);
        @(posedge clk);
        {chipSelN, procStrobeN, ctrlStrobeN, stepN, upperWrN, lowerWrN} <= ctl;
        address <= a;
        // The bus is released between writes, so stale data must not linger.
        wrData <= (ctl[1:0] != 2'h3) ? d : ~wrData;
        outEnN <= (ctl[1:0] != 2'h3) ? 1'b1 : readOeN;
        // Hold for a second clock: the block's pin filter drops one-clock changes.
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: bench/bss_control_bench.sv
// Self-checking bench for the burst static RAM control block.
// Assumes the host model drives the pins and the read FIFO drains here.
`timescale 1ns/10ps
`default_nettype none
module bss_control_bench;
    localparam logic [5:0] DESEL = 6'h37, PREAD = 6'h0c, CWRITE = 6'h14, CREAD = 6'h17;
    localparam logic [5:0] STEPR = 6'h1b, STEPW = 6'h18, HOLDR = 6'h1f, HOLDW = 6'h1c;
    localparam logic [5:0] BLOCK = 6'h2b, UPPER = 6'h15;
    localparam logic [14:0] BASE = 15'h04a7;
    logic        clk = 1'b0;
    logic        resetN = 1'b0;
    logic        readReady = 1'b1;
    logic        csN, apN, acN, advN, uwN, lwN, oeN, pinsOe, poweredUp, readValid;
    logic [14:0] addr;
    logic [17:0] wrData, pinsIn, pinsOut, readData;
    logic [17:0] mem [4];
    logic [17:0] got [$];
    int          errorCnt = 0;
    int          cmpCount = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;
    assign pinsIn = pinsOe ? pinsOut : wrData;

    bss_host i_host (.clk(clk), .chipSelN(csN), .procStrobeN(apN), .ctrlStrobeN(acN),
        .stepN(advN), .upperWrN(uwN), .lowerWrN(lwN), .outEnN(oeN), .address(addr),
        .wrData(wrData));
    bss_control i_dut (.clk(clk), .reset_n(resetN), .chip_sel_n(csN),
        .proc_addr_strobe_n(apN), .ctrl_addr_strobe_n(acN), .burst_step_n(advN),
        .upper_byte_wr_n(uwN), .lower_byte_wr_n(lwN), .out_enable_n(oeN),
        .word_address(addr), .data_pins_in(pinsIn), .data_pins_out(pinsOut),
        .data_pins_oe(pinsOe), .powered_up(poweredUp), .read_valid(readValid),
        .read_ready(readReady), .read_data(readData));

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (readValid === 1'b1 && readReady)
            got.push_back(readData);
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errorCnt++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Deselect cycles leave room for the pin pipeline and the FIFO to empty.
    task automatic settle();
        repeat (12) i_host.cycle(DESEL, BASE, 18'h00000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic writeBurst();
        got.delete();
        // Each command stands two clocks, so a step command moves the count twice.
        for (int k = 0; k < 5; k++)
            i_host.cycle(k == 0 ? CWRITE : (k[0] ? STEPW : HOLDW), BASE, 18'h2a5a0 + 18'(k));
        mem[BASE[1:0]]        = 18'h2a5a4;
        mem[BASE[1:0] ^ 2'h1] = 18'h2a5a1;
        mem[BASE[1:0] ^ 2'h2] = 18'h2a5a2;
        mem[BASE[1:0] ^ 2'h3] = 18'h2a5a3;
        settle();
        check("write reads", 18'(got.size()), 18'h00000);
    endtask

    task automatic procReadWrap();
        got.delete();
        i_host.cycle(PREAD, BASE, 18'h00000);
        repeat (2) i_host.cycle(STEPR, BASE, 18'h00000);
        settle();
        check("burst count", 18'(got.size()), 18'h00006);
        for (int k = 0; k < 6; k++)
            check("burst word", got[k], mem[BASE[1:0] ^ 2'(k == 0 ? 0 : k - 1)]);
    endtask

    task automatic procWriteWait();
        logic [17:0] old;
        old = mem[BASE[1:0]];
        got.delete();
        i_host.cycle(PREAD, BASE, 18'h00000);
        i_host.cycle(HOLDR, BASE, 18'h00000);
        i_host.cycle(HOLDW, BASE, 18'h11111);
        i_host.cycle(HOLDW, BASE, 18'h22222);
        mem[BASE[1:0]] = 18'h22222;
        i_host.cycle(CREAD, BASE, 18'h00000);
        settle();
        check("wait count", 18'(got.size()), 18'h00006);
        check("wait old", got[3], old);
        check("rewritten", got[4], mem[BASE[1:0]]);
    endtask

    task automatic byteWrite();
        got.delete();
        i_host.cycle(UPPER, BASE, 18'h3ffff);
        mem[BASE[1:0]] = {9'h1ff, mem[BASE[1:0]][8:0]};
        i_host.cycle(CREAD, BASE, 18'h00000);
        settle();
        check("upper only", got[0], mem[BASE[1:0]]);
    endtask

    task automatic blockedStrobe();
        got.delete();
        i_host.cycle(CREAD, BASE, 18'h00000);
        i_host.cycle(BLOCK, BASE ^ 15'h0203, 18'h00000);
        repeat (6) i_host.cycle(HOLDR, BASE ^ 15'h0203, 18'h00000);
        check("still up", 18'(poweredUp), 18'h00001);
        settle();
        check("first", got[0], mem[BASE[1:0]]);
        check("stepped", got[2], mem[BASE[1:0] ^ 2'h1]);
        check("stepped twice", got[3], mem[BASE[1:0] ^ 2'h2]);
        check("down", 18'(poweredUp), 18'h00000);
        check("deselect oe", 18'(pinsOe), 18'h00000);
    endtask

    task automatic powerAndEnable();
        got.delete();
        repeat (3) i_host.cycle(STEPR, BASE, 18'h00000);
        repeat (6) i_host.cycle(HOLDR, BASE, 18'h00000);
        check("stay down", 18'(poweredUp), 18'h00000);
        check("no reads", 18'(got.size()), 18'h00000);
        i_host.cycle(CREAD, BASE, 18'h00000);
        repeat (6) i_host.cycle(HOLDR, BASE, 18'h00000);
        check("up again", 18'(poweredUp), 18'h00001);
        i_host.readOeN = 1'b1;
        i_host.cycle(HOLDR, BASE, 18'h00000);
        #1 check("oe off", 18'(pinsOe), 18'h00000);
        i_host.readOeN = 1'b0;
        i_host.cycle(HOLDR, BASE, 18'h00000);
        #1 check("oe on", 18'(pinsOe), 18'h00001);
        check("pins word", pinsOut, mem[BASE[1:0]]);
        settle();
    endtask

    task automatic fifoFill();
        got.delete();
        readReady <= 1'b0;
        i_host.cycle(CREAD, BASE, 18'h00000);
        repeat (24) i_host.cycle(HOLDR, BASE, 18'h00000);
        settle();
        check("full valid", 18'(readValid), 18'h00001);
        check("held", 18'(got.size()), 18'h00000);
        readReady <= 1'b1;
        repeat (24) @(posedge clk);
        check("drained", 18'(got.size()), 18'h00010);
        check("last word", got[15], mem[BASE[1:0]]);
        check("empty", 18'(readValid), 18'h00000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        resetN <= 1'b1;
        settle();
        writeBurst();
        procReadWrap();
        procWriteWait();
        byteWrite();
        blockedStrobe();
        powerAndEnable();
        fifoFill();
        summarize();
    end
endmodule
`default_nettype wire
